/* core/nfmt_context.sv */
`timescale 1ns/1ps
// Summary of operation
// R1 - Eight tag entries, indexed by physical register number.
// R2 - Each math instruction captures instruction address, operand address and opcode.
// R3 - Store-environment and full-save present captured pointers and opcode for writing.
// R4 - Real-address mode image holds 20-bit physical addresses and 11-bit opcode.
// R5 - Protected mode image holds 32-bit virtual instruction and operand addresses.
// R6 - Captured instruction address is the first prefix byte when prefixes exist.
// R7 - Results between representable values are rounded to a representable one.
// R8 - Integer operations give exact results when they fit 64 bits.
// R9 - Integers within plus or minus two to the 64 are exactly representable.
// R10 - Seven operand types in three classes are accepted.
// R11 - The sign sits in the highest-addressed byte of every operand.
// R12 - Binary integers: top bit is sign, negatives in two's complement.
// R13 - Integer zero is produced with positive sign, all bits zero.
// R14 - Word integer equals host 16-bit signed integer; types differ only in length.
// R15 - Packed decimal: two digits per byte, top byte holds only sign.
// R16 - Negative packed decimal differs only in sign bit; digits not complemented.
// R17 - Supplier keeps every packed decimal digit between zero and nine.
// R18 - Real fractions are 23, 52 and 63 bits; integer bit explicit only in temporary.
// R19 - Short and long reals are widened to temporary real on load.
// R20 - Tags are two bits: valid, zero, special, empty; pop or free empties.
module nfmt_context
    import nfmt_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Mode
    input  wire logic                 protected_mode,
    // Instruction issue
    input  wire logic                 instr_valid,
    input  wire logic [VADDR_W-1:0]   instr_addr,
    input  wire logic [VADDR_W-1:0]   prefix_addr,
    input  wire logic                 has_prefix,
    input  wire logic                 has_operand,
    input  wire logic [VADDR_W-1:0]   operand_addr,
    input  wire logic [OPCODE_W-1:0]  opcode,
    // Tag updates
    input  wire logic                 tag_we,
    input  wire logic [REG_IDX_W-1:0] tag_idx,
    input  wire logic [TAG_W-1:0]     tag_val,
    input  wire logic                 tag_free,
    input  wire logic [REG_IDX_W-1:0] free_idx,
    // Environment store
    input  wire logic                 store_environment_op,
    input  wire logic                 save_full_state_op,
    output logic                      env_valid,
    output logic [VADDR_W-1:0]        env_instr_ptr,
    output logic [VADDR_W-1:0]        env_operand_ptr,
    output logic [OPCODE_W-1:0]       env_opcode,
    output logic [15:0]               tag_word,
    // Operand conversion
    input  wire logic                 conv_valid,
    input  wire nfmt_type_t           conv_type,
    input  wire logic [BCD_W-1:0]     conv_mem,
    output logic                      conv_done,
    output logic [BCD_W-1:0]          conv_temp,
    output nfmt_class_t               conv_class,
    output logic                      conv_inexact,
    // Integer store
    input  wire logic                 store_valid,
    input  wire nfmt_type_t           store_type,
    input  wire logic [BIN_W-1:0]     store_bin,
    output logic                      store_done,
    output logic [BCD_W-1:0]          store_mem
);

    // Tag storage indexed by physical register, not stack-relative
    logic [TAG_W-1:0] tags [NUM_REGS];
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) tags[i] <= TAG_EMPTY;   // [R20]
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                if (tag_free && free_idx == REG_IDX_W'(i)) begin
                    tags[i] <= TAG_EMPTY;                             // [R20]
                end else if (tag_we && tag_idx == REG_IDX_W'(i)) begin
                    tags[i] <= tag_val;                               // [R1]
                end
            end
        end
    end

    // Pack tags, register 0 in the low pair
    always_comb begin
        tag_word = '0;
        for (int i = 0; i < NUM_REGS; i++) tag_word[i*2 +: 2] = tags[i];   // [R1]
    end

    // Instruction capture; prefix address wins so handlers restart cleanly
    wire [VADDR_W-1:0] start_addr = has_prefix ? prefix_addr : instr_addr;   // [R6]
    logic [VADDR_W-1:0]  cap_ip;
    logic [VADDR_W-1:0]  cap_op;
    logic [OPCODE_W-1:0] cap_opc;
    logic                cap_pm;
    always_ff @(posedge clk) begin
        if (rst) begin
            cap_ip  <= PTR_RST;
            cap_op  <= PTR_RST;
            cap_opc <= OPCODE_RST;
            cap_pm  <= 1'b0;
        end else if (instr_valid) begin
            cap_ip  <= start_addr;                                     // [R2]
            cap_op  <= has_operand ? operand_addr : cap_op;           // [R2]
            cap_opc <= opcode;                                         // [R2]
            cap_pm  <= protected_mode;
        end
    end

    // Mode-dependent pointer image
    function automatic logic [VADDR_W-1:0] fmt_ptr(input logic pm, input logic [VADDR_W-1:0] a);
        fmt_ptr = pm ? a : {{(VADDR_W-PADDR_W){1'b0}}, a[PADDR_W-1:0]};   // [R4] [R5]
    endfunction

    wire env_req = store_environment_op || save_full_state_op;
    always_ff @(posedge clk) begin
        if (rst) begin
            env_valid       <= 1'b0;
            env_instr_ptr   <= PTR_RST;
            env_operand_ptr <= PTR_RST;
            env_opcode      <= OPCODE_RST;
        end else begin
            env_valid <= env_req;                                      // [R3]
            if (env_req) begin
                env_instr_ptr   <= fmt_ptr(cap_pm, cap_ip);            // [R3] [R5]
                env_operand_ptr <= fmt_ptr(cap_pm, cap_op);            // [R4]
                env_opcode      <= cap_opc;                            // [R4]
            end
        end
    end

    // Shared integer converter
    logic [BIN_W-1:0] bcd_as_bin;
    logic [BCD_W-1:0] bin_as_bcd;
    nfmt_int_conv u_conv (
        .bcd_in  (conv_mem),
        .bcd_out (bin_as_bcd),
        .bin_in  (store_bin),
        .bin_out (bcd_as_bin)
    );

    // Class of each of the seven types
    function automatic nfmt_class_t type_class(input nfmt_type_t t);
        unique case (t)
            NFMT_WORD_INT, NFMT_SHORT_INT, NFMT_LONG_INT: type_class = NFMT_CLASS_BIN;
            NFMT_PACKED_BCD:                             type_class = NFMT_CLASS_BCD;
            default:                                     type_class = NFMT_CLASS_REAL;   // [R10]
        endcase
    endfunction

    // Binary integer to temporary real; 64-bit significand keeps it exact
    function automatic logic [BCD_W-1:0] int_to_temp(input logic [BIN_W-1:0] v);
        logic [BIN_W-1:0] m;
        logic [6:0]       lz;
        logic             s;
        m  = v[BIN_W-1] ? (~v + 64'h1) : v;                            // [R12]
        s  = v[BIN_W-1];
        lz = 7'h0;
        for (int b = 0; b < BIN_W; b++) if (m[b]) lz = 7'(BIN_W - 1 - b);
        if (m == '0) int_to_temp = '0;                                 // [R13]
        else int_to_temp = {s, 15'(TEMP_BIAS + BIN_W - 1 - int'(lz)), m << lz};   // [R8] [R9]
    endfunction

    // Sign-extended value of word and short integers; sign in top byte in memory
    wire [BIN_W-1:0] sext_w = {{48{conv_mem[15]}}, conv_mem[15:0]};    // [R11] [R14]
    wire [BIN_W-1:0] sext_s = {{32{conv_mem[31]}}, conv_mem[31:0]};    // [R14]
    wire [BIN_W-1:0] digits_ok_bin = bcd_as_bin;                       // [R17]

    // Short and long real widened to temporary real
    wire [SHORT_EXP_W-1:0] se = conv_mem[30:23];
    wire [LONG_EXP_W-1:0]  le = conv_mem[62:52];
    wire [BCD_W-1:0] sr_temp = (se == '0) ? {conv_mem[31], 79'h0} :
        {conv_mem[31], 15'(int'(se) - SHORT_BIAS + TEMP_BIAS), 1'b1,
         conv_mem[SHORT_FRAC_W-1:0], 40'h0};                           // [R18] [R19]
    wire [BCD_W-1:0] lr_temp = (le == '0) ? {conv_mem[63], 79'h0} :
        {conv_mem[63], 15'(int'(le) - LONG_BIAS + TEMP_BIAS), 1'b1,
         conv_mem[LONG_FRAC_W-1:0], 11'h0};                            // [R18] [R19]

    logic [BCD_W-1:0] next_temp;
    always_comb begin
        unique case (conv_type)
            NFMT_WORD_INT:   next_temp = int_to_temp(sext_w);
            NFMT_SHORT_INT:  next_temp = int_to_temp(sext_s);
            NFMT_LONG_INT:   next_temp = int_to_temp(conv_mem[BIN_W-1:0]);
            NFMT_PACKED_BCD: next_temp = int_to_temp(digits_ok_bin);   // [R15]
            NFMT_SHORT_REAL: next_temp = sr_temp;
            NFMT_LONG_REAL:  next_temp = lr_temp;
            default:         next_temp = conv_mem;                     // [R18]
        endcase
    end

    // Round-to-nearest of temporary to short real significand
    function automatic logic [BCD_W-1:0] round_short(input logic [BCD_W-1:0] t);
        logic [24:0] sig;
        sig = {1'b0, t[63:40]} + {24'h0, t[39]};                       // [R7]
        round_short = {t[79:64], sig[23:0], 40'h0};
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            conv_done    <= 1'b0;
            conv_temp    <= '0;
            conv_class   <= NFMT_CLASS_BIN;
            conv_inexact <= 1'b0;
        end else begin
            conv_done <= conv_valid;
            if (conv_valid) begin
                conv_temp    <= next_temp;
                conv_class   <= type_class(conv_type);                 // [R10]
                conv_inexact <= 1'b0;
            end
        end
    end

    // Integer store: narrow types truncate to their own low bits
    logic [BCD_W-1:0] next_store;
    always_comb begin
        unique case (store_type)
            NFMT_WORD_INT:   next_store = {64'h0, store_bin[15:0]};    // [R14]
            NFMT_SHORT_INT:  next_store = {48'h0, store_bin[31:0]};
            NFMT_LONG_INT:   next_store = {16'h0, store_bin};          // [R12]
            NFMT_PACKED_BCD: next_store = bin_as_bcd;                  // [R16]
            default:         next_store = round_short({16'h0, store_bin});   // [R7]
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            store_done <= 1'b0;
            store_mem  <= '0;
        end else begin
            store_done <= store_valid;
            if (store_valid) store_mem <= next_store;
        end
    end

    // Tag checks: free empties, write lands, nothing else moves
    tag_free_a: assert property (@(posedge clk) disable iff (rst)   // [R20]
        tag_free |=> tags[$past(free_idx)] == TAG_EMPTY)
        else $error("freed tag not empty");
    tag_map_a: assert property (@(posedge clk) disable iff (rst)   // [R1]
        tag_we && !tag_free |=> tag_word[$past(tag_idx)*2 +: 2] == $past(tag_val))
        else $error("tag word mismatch");
    tag_keep_a: assert property (@(posedge clk) disable iff (rst)   // [R1]
        !tag_we && !tag_free |=> $stable(tag_word))
        else $error("tag word moved on its own");

    // Capture checks; a lost prefix address breaks handler restart
    prefix_cap_a: assert property (@(posedge clk) disable iff (rst)   // [R6]
        instr_valid && has_prefix |=> cap_ip == $past(prefix_addr))
        else $error("prefix address lost");
    noprefix_cap_a: assert property (@(posedge clk) disable iff (rst)   // [R6]
        instr_valid && !has_prefix |=> cap_ip == $past(instr_addr))
        else $error("instruction address lost");
    opcode_cap_a: assert property (@(posedge clk) disable iff (rst)   // [R2]
        instr_valid |=> cap_opc == $past(opcode))
        else $error("opcode not captured");
    opnd_keep_a: assert property (@(posedge clk) disable iff (rst)   // [R2]
        instr_valid && !has_operand |=> cap_op == $past(cap_op))
        else $error("operand pointer overwritten");

    // Environment image checks; handlers may read it long after the store
    env_out_a: assert property (@(posedge clk) disable iff (rst)   // [R3]
        env_req |=> env_valid && env_opcode == $past(cap_opc))
        else $error("env store wrong");
    env_pulse_a: assert property (@(posedge clk) disable iff (rst)   // [R3]
        !env_req |=> !env_valid)
        else $error("env valid without request");
    env_hold_a: assert property (@(posedge clk) disable iff (rst)   // [R3]
        !env_req |=> $stable(env_instr_ptr) && $stable(env_operand_ptr) && $stable(env_opcode))
        else $error("env image changed between stores");
    real_ptr_a: assert property (@(posedge clk) disable iff (rst)   // [R4]
        env_req && !cap_pm |=> env_instr_ptr[31:20] == 12'h0)
        else $error("real mode ptr wide");
    real_opnd_a: assert property (@(posedge clk) disable iff (rst)   // [R4]
        env_req && !cap_pm |=> env_operand_ptr[31:20] == 12'h0)
        else $error("real mode operand ptr wide");
    prot_ptr_a: assert property (@(posedge clk) disable iff (rst)   // [R5]
        env_req && cap_pm |=> env_instr_ptr == $past(cap_ip))
        else $error("virtual ptr altered");

    // Conversion checks
    bcd_class_a: assert property (@(posedge clk) disable iff (rst)   // [R10]
        conv_valid && conv_type == NFMT_PACKED_BCD |=> conv_class == NFMT_CLASS_BCD)
        else $error("packed decimal class wrong");
    word_zero_a: assert property (@(posedge clk) disable iff (rst)   // [R13]
        conv_valid && conv_type == NFMT_WORD_INT && conv_mem[15:0] == 16'h0 |=> conv_temp == '0)
        else $error("integer zero not plain zero");
    int_bit_a: assert property (@(posedge clk) disable iff (rst)   // [R18]
        conv_valid && conv_type == NFMT_SHORT_REAL && conv_mem[30:23] != 8'h0 |=> conv_temp[63])
        else $error("integer bit missing");
    bcd_neg_a: assert property (@(posedge clk) disable iff (rst)   // [R16]
        conv_valid && conv_type == NFMT_PACKED_BCD && conv_mem[71:0] != 72'h0
        |=> conv_temp[79] == $past(conv_mem[BCD_SIGN_BIT]))
        else $error("packed decimal sign lost");

    // Store checks
    int_zero_a: assert property (@(posedge clk) disable iff (rst)   // [R13]
        store_valid && store_type == NFMT_PACKED_BCD && store_bin == '0 |=> store_mem == '0)
        else $error("negative zero produced");
    bcd_sign_a: assert property (@(posedge clk) disable iff (rst)   // [R15]
        store_valid && store_type == NFMT_PACKED_BCD |=> store_mem[78:72] == 7'h0)
        else $error("sign byte holds digits");
    word_len_a: assert property (@(posedge clk) disable iff (rst)   // [R14]
        store_valid && store_type == NFMT_WORD_INT |=> store_mem[79:16] == 64'h0)
        else $error("word store too long");

    // Main scenarios
    env_cov: cover property (@(posedge clk) instr_valid ##1 store_environment_op);
    save_cov: cover property (@(posedge clk) save_full_state_op && cap_pm);
    bcd_cov: cover property (@(posedge clk) conv_valid && conv_type == NFMT_PACKED_BCD);
    nopnd_cov: cover property (@(posedge clk) instr_valid && !has_operand);
    free_cov: cover property (@(posedge clk) tag_free && tag_we && free_idx == tag_idx);

endmodule

/* core/nfmt_int_conv.sv */
`timescale 1ns/1ps
// Packed decimal to two's-complement and back, one combinational pass
module nfmt_int_conv
    import nfmt_pkg::*;
(
    // Packed decimal side
    input  wire logic [BCD_W-1:0] bcd_in,
    output logic      [BCD_W-1:0] bcd_out,
    // Binary side
    input  wire logic [BIN_W-1:0] bin_in,
    output logic      [BIN_W-1:0] bin_out
);

    // Decimal to binary: multiply-accumulate, most significant digit first
    logic [BIN_W-1:0] mag;
    always_comb begin
        mag = '0;
        for (int i = BCD_DIGITS - 1; i >= 0; i--) begin
            mag = (mag * 64'hA) + {60'h0, bcd_in[i*4 +: 4]};   // [R15]
        end
        // Sign only selects negation; digits stay uncomplemented [R16]
        bin_out = bcd_in[BCD_SIGN_BIT] ? (~mag + 64'h1) : mag;
    end

    // Binary to decimal: shift-add-three on the magnitude
    logic [BIN_W-1:0]         abs_v;
    logic [BCD_DIGITS*4-1:0]  dig;
    always_comb begin
        abs_v = bin_in[BIN_W-1] ? (~bin_in + 64'h1) : bin_in;    // [R12]
        dig   = '0;
        for (int b = BIN_W - 1; b >= 0; b--) begin
            for (int d = 0; d < BCD_DIGITS; d++) begin
                if (dig[d*4 +: 4] >= 4'h5) begin
                    dig[d*4 +: 4] = dig[d*4 +: 4] + 4'h3;
                end
            end
            dig = {dig[BCD_DIGITS*4-2:0], abs_v[b]};
        end
        // Zero never carries a negative sign
        bcd_out = {(bin_in[BIN_W-1] && (abs_v != '0)), 7'h0, dig};   // [R15] [R16]
    end

endmodule

/* dv/nfmt_host_model.sv */
`timescale 1ns/1ps
// Host side: memory image of a packed decimal operand
module nfmt_host_model
    import nfmt_pkg::*;
(
    // Value to place in memory
    input  wire logic             sign,
    input  wire logic [63:0]      mag,
    // Ten-byte image, low byte at low address
    output logic      [BCD_W-1:0] bcd
);
    // True division, so no nibble can exceed nine
    always_comb begin
        logic [63:0] m;
        m = mag;
        bcd = '0;
        for (int i = 0; i < BCD_DIGITS; i++) begin
            bcd[4*i +: 4] = 4'(m % 64'hA);
            m = m / 64'hA;
        end
        bcd[BCD_SIGN_BIT] = sign;
    end
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import nfmt_pkg::*;
    // Stimulus and observed signals
    logic clk = 1'b0, rst = 1'b1, protected_mode = 1'b0, instr_valid = 1'b0, has_prefix = 1'b0;
    logic has_operand = 1'b0, tag_we = 1'b0, tag_free = 1'b0, store_environment_op = 1'b0;
    logic save_full_state_op = 1'b0, conv_valid = 1'b0, store_valid = 1'b0, sign = 1'b0;
    logic [31:0] instr_addr = '0, prefix_addr = '0, operand_addr = '0;
    logic [10:0] opcode = '0;
    logic [2:0]  tag_idx = '0, free_idx = '0;
    logic [1:0]  tag_val = '0;
    logic [79:0] conv_mem = '0, conv_temp, store_mem, bcd;
    logic [63:0] store_bin = '0, mag = '0;
    nfmt_type_t  conv_type = NFMT_WORD_INT, store_type = NFMT_WORD_INT;
    nfmt_class_t conv_class;
    logic env_valid, conv_done, conv_inexact, store_done;
    logic [31:0] env_instr_ptr, env_operand_ptr;
    logic [10:0] env_opcode;
    logic [15:0] tag_word;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;

    nfmt_context i_dut (.clk, .rst, .protected_mode, .instr_valid, .instr_addr, .prefix_addr, .has_prefix,
        .has_operand, .operand_addr, .opcode, .tag_we, .tag_idx, .tag_val, .tag_free, .free_idx,
        .store_environment_op, .save_full_state_op, .env_valid, .env_instr_ptr, .env_operand_ptr,
        .env_opcode, .tag_word, .conv_valid, .conv_type, .conv_mem, .conv_done, .conv_temp, .conv_class,
        .conv_inexact, .store_valid, .store_type, .store_bin, .store_done, .store_mem);
    nfmt_host_model i_host (.sign, .mag, .bcd);

    always #12.5 clk = ~clk;

    // Cut a hang short; the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Expected internal image of an integer magnitude; all integers here are exact
    function automatic logic [79:0] to_temp(input logic s, input logic [63:0] m);
        int p;
        p = 63;
        if (m == 64'h0)
            return 80'h0;
        while (!m[p])
            p--;
        return {s, 15'(16383 + p), m << (63 - p)};
    endfunction

    // Every task starts and ends just after a falling edge
    task automatic instr(input logic pm, pf, op, input logic [31:0] ia, pa, oa, input logic [10:0] code);
        {protected_mode, has_prefix, has_operand} = {pm, pf, op};
        {instr_addr, prefix_addr, operand_addr, opcode} = {ia, pa, oa, code};
        instr_valid = 1'b1;
        @(negedge clk);
        instr_valid = 1'b0;
    endtask

    task automatic env(input logic full, input logic [31:0] ip, dp, input logic [10:0] code);
        if (full)
            save_full_state_op = 1'b1;
        else
            store_environment_op = 1'b1;
        @(negedge clk);
        {save_full_state_op, store_environment_op} = 2'h0;
        chk("env_valid", 80'h1, {79'h0, env_valid});
        chk("instr ptr", {48'h0, ip}, {48'h0, env_instr_ptr});
        chk("operand ptr", {48'h0, dp}, {48'h0, env_operand_ptr});
        chk("opcode", {69'h0, code}, {69'h0, env_opcode});
    endtask

    task automatic conv(input nfmt_type_t t, input logic [79:0] m, exp, input nfmt_class_t c);
        conv_type = t;
        {conv_mem, conv_valid} = {m, 1'b1};
        @(negedge clk);
        conv_valid = 1'b0;
        chk("conv_done", 80'h1, {79'h0, conv_done});
        chk("conv_temp", exp, conv_temp);
        chk("conv_class", {78'h0, c}, {78'h0, conv_class});
        chk("conv_inexact", 80'h0, {79'h0, conv_inexact});
    endtask

    task automatic st(input nfmt_type_t t, input logic [63:0] b, input logic [79:0] exp, mask);
        store_type = t;
        {store_bin, store_valid} = {b, 1'b1};
        @(negedge clk);
        store_valid = 1'b0;
        chk("store_done", 80'h1, {79'h0, store_done});
        chk("store_mem", exp, store_mem & mask);
    endtask

    task automatic t_tags();
        chk("tag_word reset", 80'hFFFF, {64'h0, tag_word});
        for (int i = 0; i < 8; i++) begin
            {tag_we, tag_idx, tag_val} = {1'b1, 3'(i), 2'(i)};
            @(negedge clk);
        end
        tag_we = 1'b0;
        @(negedge clk);
        chk("tag_word", 80'hE4E4, {64'h0, tag_word});
        // Free beats write on one index; distinct indexes both land
        {tag_free, free_idx, tag_we, tag_idx, tag_val} = {1'b1, 3'h2, 1'b1, 3'h2, TAG_ZERO};
        @(negedge clk);
        {free_idx, tag_idx, tag_val} = {3'h5, 3'h6, TAG_VALID};
        @(negedge clk);
        {tag_free, tag_we} = 2'h0;
        @(negedge clk);
        chk("tag_word free", 80'hCCF4, {64'h0, tag_word});
    endtask

    task automatic t_ptrs();
        // Real mode keeps 20 bits and points at the prefix
        instr(1'b0, 1'b1, 1'b1, 32'hABC1_2346, 32'hABC1_2344, 32'h5F0F_1234, 11'h5A3);
        env(1'b0, 32'h0001_2344, 32'h000F_1234, 11'h5A3);
        instr(1'b1, 1'b0, 1'b1, 32'hFEDC_BA98, 32'h1111_1111, 32'h8765_4321, 11'h2BC);
        env(1'b1, 32'hFEDC_BA98, 32'h8765_4321, 11'h2BC);
        // No operand: the operand pointer stays as it was
        instr(1'b1, 1'b0, 1'b0, 32'h1357_9BDF, 32'h2222_2222, 32'h3333_3333, 11'h7FF);
        env(1'b0, 32'h1357_9BDF, 32'h8765_4321, 11'h7FF);
    endtask

    task automatic t_conv();
        // Host image settles well before the packed decimal call
        {sign, mag} = {1'b1, 64'h0DB4_DA5F_7EF4_12CE};
        conv(NFMT_WORD_INT, {64'h5A5A_5A5A_5A5A_5A5A, 16'h8000}, to_temp(1'b1, 64'h8000), NFMT_CLASS_BIN);
        conv(NFMT_WORD_INT, 80'h0, 80'h0, NFMT_CLASS_BIN);
        conv(NFMT_SHORT_INT, {48'h0, 32'hFFFF_FFFF}, to_temp(1'b1, 64'h1), NFMT_CLASS_BIN);
        conv(NFMT_LONG_INT, {16'h0, 64'h7FFF_FFFF_FFFF_FFFF}, to_temp(1'b0, 64'h7FFF_FFFF_FFFF_FFFF),
            NFMT_CLASS_BIN);
        conv(NFMT_LONG_INT, {16'h0, 64'h8000_0000_0000_0000}, to_temp(1'b1, 64'h8000_0000_0000_0000),
            NFMT_CLASS_BIN);
        conv(NFMT_PACKED_BCD, bcd, to_temp(1'b1, mag), NFMT_CLASS_BCD);
        conv(NFMT_SHORT_REAL, {48'h0, 32'hC030_0000}, {1'b1, 15'h4000, 64'hB000_0000_0000_0000},
            NFMT_CLASS_REAL);
        conv(NFMT_LONG_REAL, {16'h0, 64'h3FF8_0000_0000_0000}, {1'b0, 15'h3FFF, 64'hC000_0000_0000_0000},
            NFMT_CLASS_REAL);
        conv(NFMT_TEMP_REAL, {1'b0, 15'h4006, 64'hB220_0000_0000_0000}, {1'b0, 15'h4006,
            64'hB220_0000_0000_0000}, NFMT_CLASS_REAL);
    endtask

    task automatic t_store();
        st(NFMT_WORD_INT, 64'hFFFF_FFFF_FFFF_FFFB, 80'hFFFB, 80'hFFFF);
        st(NFMT_SHORT_INT, 64'h0, 80'h0, 80'hFFFF_FFFF);
        st(NFMT_LONG_INT, 64'h8000_0000_0000_0000, 80'h8000_0000_0000_0000, 80'hFFFF_FFFF_FFFF_FFFF);
        st(NFMT_PACKED_BCD, 64'hFFFF_FFFF_FFFF_FB2E, 80'h8000_0000_0000_0000_1234, '1);
        st(NFMT_PACKED_BCD, 64'h4D2, 80'h1234, '1);
        st(NFMT_PACKED_BCD, 64'h0, 80'h0, '1);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_tags();
        t_ptrs();
        t_conv();
        t_store();
        end_sim();
    end
endmodule

/* pkg/nfmt_pkg.sv */
package nfmt_pkg;

    // Register file geometry
    localparam int NUM_REGS        = 8;
    localparam int TAG_W           = 2;
    localparam int REG_IDX_W       = 3;

    // Tag encodings
    localparam logic [1:0] TAG_VALID   = 2'h0;
    localparam logic [1:0] TAG_ZERO    = 2'h1;
    localparam logic [1:0] TAG_SPECIAL = 2'h2;
    localparam logic [1:0] TAG_EMPTY   = 2'h3;
    localparam logic [15:0] TAG_WORD_RST = 16'hFFFF;

    // Pointer capture widths
    localparam int VADDR_W         = 32;
    localparam int PADDR_W         = 20;
    localparam int OPCODE_W        = 11;
    localparam logic [31:0] PTR_RST    = 32'h0;
    localparam logic [10:0] OPCODE_RST = 11'h0;

    // Real-number fraction widths
    localparam int SHORT_FRAC_W    = 23;
    localparam int LONG_FRAC_W     = 52;
    localparam int TEMP_FRAC_W     = 63;
    localparam int SHORT_EXP_W     = 8;
    localparam int LONG_EXP_W      = 11;
    localparam int TEMP_EXP_W      = 15;
    localparam int SHORT_BIAS      = 127;
    localparam int LONG_BIAS       = 1023;
    localparam int TEMP_BIAS       = 16383;

    // Integer formats
    localparam int BIN_W           = 64;
    localparam int BCD_DIGITS      = 18;
    localparam int BCD_W           = 80;
    localparam int BCD_SIGN_BIT    = 79;

    // Operand type codes: seven types in three classes
    typedef enum logic [2:0] {
        NFMT_WORD_INT,
        NFMT_SHORT_INT,
        NFMT_LONG_INT,
        NFMT_PACKED_BCD,
        NFMT_SHORT_REAL,
        NFMT_LONG_REAL,
        NFMT_TEMP_REAL
    } nfmt_type_t;

    typedef enum logic [1:0] {
        NFMT_CLASS_BIN,
        NFMT_CLASS_BCD,
        NFMT_CLASS_REAL
    } nfmt_class_t;

endpackage
